/* File: src/adc_repeat_sweep_control.sv */
// repeat sweep sequencer with axi4-lite register slave and result store
`timescale 1ns/1ps
module adc_repeat_sweep_control
  import adc_sweep_pkg::*;
(
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // external trigger pin, falling edge starts
  input  wire logic                extTrigger_b,
  // analogue front end
  output conv_ctl_t                convCtl,
  output logic                     refConnect,
  input  wire logic                convDone,
  input  wire logic [RESULT_W-1:0] convData
);

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic reg_sel_t decodeReg(input logic [ADDR_W-1:0] a);
    if (a == ADDR_MODE_CTL) return SEL_MODE;
    if (a == ADDR_SWEEP_CFG) return SEL_SWEEP;
    if (a == ADDR_AUX_CFG) return SEL_AUX;
    if (a[ADDR_W-1:5] == ADDR_RESULT0[ADDR_W-1:5] && a[1:0] == 2'h0) return SEL_RES;
    return SEL_NONE;
  endfunction : decodeReg

  // highest input of the plain sweep, or highest priority input
  function automatic logic [CH_W-1:0] chanLimit(input logic [1:0] sel, input logic prio);
    return prio ? {1'b0, sel} : {sel, 1'b1};
  endfunction : chanLimit

  // ------------------------------------------------------------------
  // register fields
  // ------------------------------------------------------------------
  logic [7:0]       modeCtl_reg;
  logic [7:0]       sweepCfg_reg;
  logic [AUX_W-1:0] auxCfg_reg;
  logic             startFlag;
  logic             repeatOn;
  logic             running;
  logic             variant1;
  logic             trigExt;
  logic             wideRes;
  logic [1:0]       sweepSel;
  logic [CH_W-1:0]  sweepLast;
  logic [CH_W-1:0]  prioLast;

  // channel select bits of the mode register are stored and read back but never used by the sequencer
  assign startFlag = modeCtl_reg[MC_START]; // R12
  assign repeatOn  = modeCtl_reg[MC_MODE_LSB +: 2] == MODE_REPEAT; // R1 R14
  assign running   = startFlag && repeatOn;
  assign variant1  = sweepCfg_reg[SC_EXT]; // R2 R3
  assign trigExt   = modeCtl_reg[MC_TRIG]; // R8
  assign wideRes   = sweepCfg_reg[SC_WIDE]; // R15
  assign sweepSel  = sweepCfg_reg[SC_SEL_LSB +: 2];
  assign sweepLast = chanLimit(sweepSel, 1'b0); // R5
  assign prioLast  = chanLimit(sweepSel, 1'b1); // R6

  // ------------------------------------------------------------------
  // axi write channels
  // ------------------------------------------------------------------
  logic              awHeld;
  logic              wHeld;
  logic              wLane0_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0]       wData_reg;
  logic              doWrite;
  reg_sel_t          wrSel;

  // address and data may arrive in either order; write once both held
  assign doWrite = awHeld && wHeld && !bvalid;
  assign wrSel   = decodeReg(awAddr_reg);

  // handshakes and the write response
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      wLane0_reg <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHeld     <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_reg  <= wdata;
        wLane0_reg <= wstrb[0];
        wHeld      <= 1'b1;
        wready     <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
      end
      // ready drops until the response is taken: one write at a time
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // software registers; result slots ignore writes, lane 0 only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modeCtl_reg  <= MODE_CTL_RST;
      sweepCfg_reg <= SWEEP_CFG_RST;
      auxCfg_reg   <= AUX_CFG_RST;
    end else if (ce && doWrite && wLane0_reg) begin
      case (wrSel)
        SEL_MODE:  modeCtl_reg  <= wData_reg[7:0]; // R11
        SEL_SWEEP: sweepCfg_reg <= wData_reg[7:0];
        SEL_AUX:   auxCfg_reg   <= wData_reg[AUX_W-1:0];
        default:   ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // axi read channels
  // ------------------------------------------------------------------
  logic              rdStep1;
  logic              rdStep2;
  logic [ADDR_W-1:0] arAddr_reg;
  logic [31:0]       readMux;
  logic [RESULT_W-1:0] memQ;
  logic [CH_W-1:0]   curCh;

  // read mux; aux upper bits show the input now being converted
  always_comb begin
    case (decodeReg(arAddr_reg))
      SEL_MODE:  readMux = 32'(modeCtl_reg);
      SEL_SWEEP: readMux = 32'(sweepCfg_reg);
      SEL_AUX:   readMux = 32'({curCh, auxCfg_reg});
      SEL_RES:   readMux = 32'(memQ);
      default:   readMux = '0;
    endcase
  end

  // two steps after the address: memory read, then data register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready    <= 1'b1;
      arAddr_reg <= '0;
      rdStep1    <= 1'b0;
      rdStep2    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= RESP_OKAY;
    end else if (ce) begin
      rdStep1 <= arvalid && arready;
      rdStep2 <= rdStep1;
      if (arvalid && arready) begin
        arAddr_reg <= araddr;
        arready    <= 1'b0;
      end
      if (rdStep2) begin
        rvalid <= 1'b1;
        rdata  <= readMux;
        rresp  <= (decodeReg(arAddr_reg) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // external trigger: synchroniser and falling edge
  // ------------------------------------------------------------------
  logic trigMeta;
  logic trigSync;
  logic trigPrev;
  logic trigFall;

  // pin is asynchronous; edge is taken after the second stage only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trigMeta <= 1'b1;
      trigSync <= 1'b1;
      trigPrev <= 1'b1;
    end else if (ce) begin
      trigMeta <= extTrigger_b;
      trigSync <= trigMeta;
      trigPrev <= trigSync;
    end
  end

  assign trigFall = trigPrev && !trigSync; // R10

  // ------------------------------------------------------------------
  // sweep sequencer
  // ------------------------------------------------------------------
  seq_state_t      state;
  seq_state_t      stateNext;
  logic            prioPhase;
  logic            prioPhaseNext;
  logic [CH_W-1:0] curChNext;
  logic [CH_W-1:0] prioIdx;
  logic [CH_W-1:0] prioIdxNext;
  logic [CH_W-1:0] normIdx;
  logic [CH_W-1:0] normIdxNext;

  // next state and next input of the sweep
  always_comb begin
    stateNext     = state;
    curChNext     = curCh;
    prioPhaseNext = prioPhase;
    prioIdxNext   = prioIdx;
    normIdxNext   = normIdx;
    case (state)
      ST_IDLE: begin
        if (running) begin
          curChNext     = '0;
          prioPhaseNext = 1'b1;
          prioIdxNext   = '0;
          normIdxNext   = prioLast + 3'h1;
          stateNext     = trigExt ? ST_ARMED : ST_ISSUE; // R8 R9
        end
      end
      ST_ARMED: begin
        // edges before the flag was set were never looked at
        if (!running) begin
          stateNext = ST_IDLE;
        end else if (trigFall) begin
          stateNext = ST_ISSUE; // R10
        end
      end
      ST_ISSUE: stateNext = running ? ST_WAIT : ST_IDLE;
      ST_WAIT: begin
        if (!running) begin
          stateNext = ST_IDLE; // R11 R22
        end else if (convDone) begin
          stateNext = ST_ISSUE; // R4
          if (!variant1) begin
            curChNext = (curCh == sweepLast) ? '0 : curCh + 3'h1; // R4 R5
          end else if (prioPhase) begin
            curChNext     = normIdx; // R7
            prioPhaseNext = 1'b0;
            normIdxNext   = (normIdx == LAST_INPUT) ? prioLast + 3'h1 : normIdx + 3'h1;
          end else begin
            prioIdxNext   = (prioIdx == prioLast) ? '0 : prioIdx + 3'h1; // R6 R7
            curChNext     = prioIdxNext;
            prioPhaseNext = 1'b1;
          end
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      curCh     <= '0;
      prioPhase <= 1'b0;
      prioIdx   <= '0;
      normIdx   <= '0;
    end else if (ce) begin
      state     <= stateNext;
      curCh     <= curChNext;
      prioPhase <= prioPhaseNext;
      prioIdx   <= prioIdxNext;
      normIdx   <= normIdxNext;
    end
  end

  // front end requests; group select passes through untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convCtl    <= '0;
      refConnect <= 1'b0;
    end else if (ce) begin
      convCtl.start <= (stateNext == ST_ISSUE);
      convCtl.abort <= (state == ST_WAIT || state == ST_ISSUE) && stateNext == ST_IDLE; // R22
      convCtl.wide  <= wideRes; // R15
      convCtl.group <= auxCfg_reg[AUX_GRP_LSB +: 2]; // R18
      convCtl.chan  <= curChNext; // R14
      refConnect    <= sweepCfg_reg[SC_VREF];
    end
  end

  // ------------------------------------------------------------------
  // result store
  // ------------------------------------------------------------------
  logic                memWe;
  logic [RESULT_W-1:0] memWdata;

  // completion only updates the slot; nothing is signalled to software
  assign memWe    = state == ST_WAIT && running && convDone; // R13 R21
  assign memWdata = wideRes ? convData : RESULT_W'(convData[NARROW_W-1:0]); // R20

  result_store #(.W(RESULT_W), .D(NUM_INPUTS), .A(CH_W)) resultMem (
    .clk(clk), .rst_b(rst_b), .ce(ce), .we(memWe), .wrAddr(curCh), .wrData(memWdata),
    .rdAddr(arAddr_reg[CH_W+1:2]), .rdData(memQ)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence swStartSeq;
    ce && state == ST_IDLE && running && !trigExt;
  endsequence
  sequence armWaitSeq;
    ce && state == ST_ARMED && running && !trigFall;
  endsequence
  a_repeat_mode_only: assert property (convCtl.start |-> $past(repeatOn)) // R1
    else $error("conversion issued outside repeat sweep mode");
  a_sw_start_issue: assert property (swStartSeq |=> state == ST_ISSUE && convCtl.start) // R9
    else $error("software start did not issue a conversion");
  a_ext_armed_wait: assert property (armWaitSeq |=> state == ST_ARMED && !convCtl.start) // R10
    else $error("armed sweep left without a trigger edge");
  a_v0_range_limit: assert property (convCtl.start && !variant1 |-> convCtl.chan <= sweepLast) // R5
    else $error("plain sweep input beyond selected group");
  a_v1_prio_slot: assert property (convCtl.start && variant1 && prioPhase |-> convCtl.chan <= prioLast) // R6
    else $error("priority slot used a non priority input");
  a_v1_alternate: assert property (ce && variant1 && memWe |=> prioPhase != $past(prioPhase)) // R7
    else $error("priority and normal slots did not alternate");
  a_flag_no_self: assert property (ce && startFlag && !(doWrite && wrSel == SEL_MODE) |=> startFlag) // R11
    else $error("start flag dropped without a software write");
  a_stop_to_idle: assert property (ce && !startFlag |=> state == ST_IDLE) // R22
    else $error("sweep kept running with start flag clear");
  a_result_slot: assert property (memWe |-> convCtl.chan == curCh && !convCtl.start) // R13
    else $error("result stored to a slot other than the converted input");
  a_narrow_result: assert property (memWe && !wideRes |-> memWdata[RESULT_W-1:NARROW_W] == '0) // R20
    else $error("8-bit result has upper bits set");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response withdrawn before taken");

endmodule : adc_repeat_sweep_control

/* File: src/adc_sweep_pkg.sv */
// constants, types and register layout for the repeat sweep controller
// Notes on behaviour
// R1 - mode field value 11 selects a repeat sweep, variant 0 or 1
// R2 - software clears the extra mode bit for variant 0
// R3 - software sets the extra mode bit for priority variant 1
// R4 - variant 0 converts selected inputs in turn and wraps endlessly
// R5 - variant 0 sweep select picks inputs 0-1, 0-3, 0-5 or 0-7
// R6 - variant 1 sweep select picks priority inputs 0, 0-1, 0-2 or 0-3
// R7 - variant 1 converts all eight inputs, a priority input between each
// R8 - trigger select 0 is software start, 1 is external pin
// R9 - software start begins the sweep when start flag written 1
// R10 - external start begins only on pin falling edge after flag set
// R11 - sweep stops only when software writes 0 to start flag
// R12 - start flag 0 means disabled, 1 means started
// R13 - each result goes into the result register of its input number
// R14 - single channel select field has no effect in repeat sweep
// R15 - resolution bit 0 selects 8-bit, 1 selects 10-bit
// R16 - software must not rewrite mode control during conversion
// R17 - software waits 1 us after connecting reference before starting
// R18 - alternate port groups sweep exactly like primary inputs
// R19 - software connects reference before, never with, start flag
// R20 - results sit in bits 0-9 for 10-bit, bits 0-7 for 8-bit
// R21 - no conversion-complete interrupt in either repeat variant
// R22 - clearing start abandons conversion, completed results stay
package adc_sweep_pkg;

  // ----------------------------------------------------------------
  // register map: indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          IDX_SWEEP_CFG = 32'h0000_03D7;
  localparam int          IDX_MODE_CTL  = 32'h0000_03D6;
  localparam int          IDX_AUX_CFG   = 32'h0000_03D4;
  localparam int          IDX_RESULT0   = 32'h0000_03C0;
  localparam logic [11:0] ADDR_SWEEP_CFG = 12'(IDX_SWEEP_CFG * 4);
  localparam logic [11:0] ADDR_MODE_CTL  = 12'(IDX_MODE_CTL * 4);
  localparam logic [11:0] ADDR_AUX_CFG   = 12'(IDX_AUX_CFG * 4);
  localparam logic [11:0] ADDR_RESULT0   = 12'(IDX_RESULT0 * 4);

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CTL_RST  = 8'h00;
  localparam logic [7:0] SWEEP_CFG_RST = 8'h00;
  localparam logic [4:0] AUX_CFG_RST   = 5'h00;
  localparam int MC_MODE_LSB = 3;
  localparam int MC_TRIG     = 5;
  localparam int MC_START    = 6;
  localparam int SC_SEL_LSB  = 0;
  localparam int SC_EXT      = 2;
  localparam int SC_WIDE     = 3;
  localparam int SC_VREF     = 5;
  localparam int AUX_GRP_LSB = 1;
  localparam int AUX_W       = 5;

  // ----------------------------------------------------------------
  // encodings and sizes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         NUM_INPUTS  = 8;
  localparam int         CH_W        = 3;
  localparam logic [2:0] LAST_INPUT  = 3'h7;
  localparam int         RESULT_W    = 10;
  localparam int         NARROW_W    = 8;

  typedef enum logic [2:0] {SEL_MODE, SEL_SWEEP, SEL_AUX, SEL_RES, SEL_NONE} reg_sel_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ISSUE, ST_WAIT} seq_state_t;

  // request bundle to the analogue front end
  typedef struct packed {
    logic            start;
    logic            abort;
    logic            wide;
    logic [1:0]      group;
    logic [CH_W-1:0] chan;
  } conv_ctl_t;

endpackage : adc_sweep_pkg

/* File: src/result_store.sv */
// small result memory, one word per analogue input, registered read
`timescale 1ns/1ps
module result_store #(
  parameter int W = 10,
  parameter int D = 8,
  parameter int A = 3
) (
  // clock and enable
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // write port
  input  wire logic         we,
  input  wire logic [A-1:0] wrAddr,
  input  wire logic [W-1:0] wrData,
  // read port
  input  wire logic [A-1:0] rdAddr,
  output logic      [W-1:0] rdData
);

  logic [W-1:0] mem [D];

  // array has no reset, so unwritten slots read as whatever was there
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[wrAddr] <= wrData;
    end
  end

  // read data always leaves through a register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : result_store

/* File: tb/adc_front_end_model.sv */
// behavioural analogue front end answering each conversion request that is not aborted
`timescale 1ns/1ps
module adc_front_end_model
  import adc_sweep_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // request side
  input  wire conv_ctl_t           convCtl,
  input  wire logic                slow,
  // answer side
  output logic                     convDone,
  output logic [RESULT_W-1:0]      convData
);
  int                  cnt;
  logic                fire;
  logic [RESULT_W-1:0] val;
  // ------------------------------------------------
  // conversion timer and result pattern
  // ------------------------------------------------
  // data lines toggle between results so a stale word never looks valid
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt = 0;
      val = 10'h2a5;
      convDone <= 1'b0;
      convData <= '0;
    end else begin
      fire = 1'b0;
      if (convCtl.abort) cnt = 0;
      else if (convCtl.start) cnt = slow ? 12 : 2;
      else if (cnt > 1) cnt--;
      else if (cnt == 1) begin
        cnt = 0;
        fire = 1'b1;
        val = val * 10'h005 + 10'h07b;
      end
      convDone <= fire;
      convData <= fire ? val : ~convData;
    end
  end
endmodule : adc_front_end_model

/* File: tb/adc_repeat_sweep_control_tb.sv */
// self-checking bench for the repeat sweep controller
`timescale 1ns/1ps
module adc_repeat_sweep_control_tb
  import adc_sweep_pkg::*;
;
  // ------------------------------------------------
  // ports and bench model state
  // ------------------------------------------------
  logic                clk, rst_b, ce, slow, extTrigger_b, refConnect, convDone;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic                awvalid, awready, wvalid, wready, bvalid, bready;
  logic                arvalid, arready, rvalid, rready;
  logic [31:0]         wdata, rdata;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, grp;
  logic [RESULT_W-1:0] convData;
  conv_ctl_t           convCtl;
  int                  miscompares, nTests, nAbort, cyc;
  logic [2:0]          seen[$];
  logic [2:0]          curCh;
  logic [9:0]          expRes[8];
  bit                  have[8];
  logic                wide;
  logic [31:0]         lfsrState = 32'he2d1_662f;

  adc_repeat_sweep_control adc_repeat_sweep_control_inst (
    .clk, .rst_b, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .extTrigger_b, .convCtl,
    .refConnect, .convDone, .convData);
  adc_front_end_model adc_front_end_model_inst (.clk, .rst_b, .convCtl, .slow, .convDone, .convData);

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      $display("BAD %s expected %0h seen %0h", name, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic testDone;
    if (miscompares == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : testDone

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= 32'(d);
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(n, e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask : rd

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected input of the i-th conversion for a variant and sweep select
  function automatic int expCh(input int v, input int sel, input int i);
    if (v == 0) return i % (2 * sel + 2);
    if (i % 2 == 0) return (i / 2) % (sel + 1);
    return sel + 1 + (i / 2) % (7 - sel);
  endfunction : expCh

  // ------------------------------------------------
  // front end monitor and hang guard
  // ------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      testDone();
    end
    if (convCtl.start) begin
      seen.push_back(convCtl.chan);
      curCh = convCtl.chan;
      chk("group", 32'(grp), 32'(convCtl.group));
      chk("wide", 32'(wide), 32'(convCtl.wide));
    end
    if (convDone) begin
      expRes[curCh] = wide ? convData : (convData & 10'h0ff);
      have[curCh] = 1'b1;
    end
    if (convCtl.abort) nAbort++;
  end

  // one sweep run: configure, start, let it wrap, stop, check order and results
  task automatic run(input int v, input int sel, input bit trig);
    int         t;
    logic [7:0] cfg;
    lfsrState = lfsr(lfsrState);
    grp = lfsrState[1:0];
    wide = lfsrState[2];
    slow <= 1'b0;
    nAbort = 0;
    seen.delete();
    cfg = {3'b001, 1'b0, wide, v[0], sel[1:0]};
    wr(ADDR_AUX_CFG, {3'b000, lfsrState[4:3], grp, lfsrState[5]}, 4'hf, RESP_OKAY);
    wr(ADDR_SWEEP_CFG, cfg, 4'hf, RESP_OKAY);
    rd("sweep", ADDR_SWEEP_CFG, 32'(cfg), RESP_OKAY);
    if (trig) extTrigger_b <= 1'b0;
    wr(ADDR_MODE_CTL, {lfsrState[8], 1'b1, trig, 2'b11, lfsrState[11:9]}, 4'hf, RESP_OKAY);
    if (trig) begin
      repeat (20) @(posedge clk);
      chk("early start", 0, seen.size());
      extTrigger_b <= 1'b1;
      repeat (5) @(posedge clk);
      extTrigger_b <= 1'b0;
    end
    for (t = 0; t < 500 && seen.size() < 16; t++) @(posedge clk);
    slow <= 1'b1;
    for (t = 0; t < 100 && seen.size() < 17; t++) @(posedge clk);
    wr(ADDR_MODE_CTL, {lfsrState[8], 1'b0, trig, 2'b11, lfsrState[11:9]}, 4'hf, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk("starts", 17, seen.size());
    chk("aborts", 1, nAbort);
    for (t = 0; t < 17; t++) chk("chan", expCh(v, sel, t), 32'(seen[t]));
    for (t = 0; t < 8; t++) if (have[t]) rd("result", ADDR_RESULT0 + 12'(4 * t), 32'(expRes[t]), RESP_OKAY);
  endtask : run

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {ce, extTrigger_b} = 2'b11;
    {awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd("mode rst", ADDR_MODE_CTL, 32'(MODE_CTL_RST), RESP_OKAY);
    rd("sweep rst", ADDR_SWEEP_CFG, 32'(SWEEP_CFG_RST), RESP_OKAY);
    rd("aux rst", ADDR_AUX_CFG, 32'(AUX_CFG_RST), RESP_OKAY);
    rd("unmapped", 12'hffc, 0, RESP_SLVERR);
    wr(12'hffc, 8'h5a, 4'hf, RESP_SLVERR);
    wr(ADDR_SWEEP_CFG, 8'h20, 4'hf, RESP_OKAY);
    repeat (50) @(posedge clk);
    chk("refConnect", 1, 32'(refConnect));
    wr(ADDR_SWEEP_CFG, 8'hdf, 4'h0, RESP_OKAY);
    rd("strobe off", ADDR_SWEEP_CFG, 32'h0000_0020, RESP_OKAY);
    for (int v = 0; v < 2; v++) for (int s = 0; s < 4; s++) run(v, s, 1'b0);
    run(0, 1, 1'b1);
    testDone();
  end
endmodule : adc_repeat_sweep_control_tb
